/* src/dtp_pkg.sv */
// shared constants and types of the debug and trace port
package dtp_pkg;
   // register port geometry
   localparam int ADDR_W = 4;
   localparam int DATA_W = 32;

   // register byte offsets
   localparam logic [3:0] REG_MSR = 4'h0;
   localparam logic [3:0] REG_DSR = 4'h4;
   localparam logic [3:0] REG_DCR = 4'h8;
   localparam logic [3:0] REG_HCMD = 4'hC;

   // machine state register fields
   localparam int MSR_WE_BIT = 0;
   // debug status register fields
   localparam int DSR_UDE_BIT = 0;
   localparam int DSR_HALTED_BIT = 1;
   localparam int DSR_PEND_BIT = 2;
   localparam int DSR_BUSHOLD_BIT = 3;
   localparam int DSR_WAIT_BIT = 4;
   // debug control register fields
   localparam int DCR_IDM_BIT = 0;
   localparam int DCR_EDM_BIT = 1;
   // halt command register fields
   localparam int HCMD_HALT_BIT = 0;
   localparam int HCMD_STOP_BIT = 1;

   // reset values
   localparam logic [31:0] RST_WORD = 32'h0000_0000;
   localparam logic [1:0] RST_DCR = 2'h0;

   // port widths and trace layout
   localparam int WB_ADDR_W = 30;
   localparam int TRIG_W = 11;
   localparam int CORE_EVT_W = 10;
   localparam int EXEC_W = 2;
   localparam int TSTAT_W = 4;
   localparam int TRIG_UNCOND_BIT = 10;
   localparam int TS_TRIG_BIT = 3;
   localparam int PIN_CNT = 5;

   // halt sequencing
   typedef enum logic [1:0] {
      HLT_RUN,
      HLT_PEND,
      HLT_STOP
   } dtp_halt_type;
endpackage : dtp_pkg

/* src/dtp_trace_if.sv */
// carrier between the port core and the trace packer
`timescale 1ns/1ps
interface dtp_trace_if;
   import dtp_pkg::*;
   logic [EXEC_W-1:0] exec_status;
   logic [TSTAT_W-1:0] trace_status;
   logic [TRIG_W-1:0] trig_type;
   logic trig_allow;
   logic trig_in;
   logic trace_off;
   logic trace_cycle;
   logic [EXEC_W-1:0] exec_first;
   logic [EXEC_W-1:0] exec_second;
   logic [TSTAT_W-1:0] tstatus;
   logic trigger;
   logic [TRIG_W-1:0] trigger_type;

   modport core (output exec_status, trace_status, trig_type, trig_allow, trig_in, trace_off,
      input trace_cycle, exec_first, exec_second, tstatus, trigger, trigger_type);
   modport packer (input exec_status, trace_status, trig_type, trig_allow, trig_in, trace_off,
      output trace_cycle, exec_first, exec_second, tstatus, trigger, trigger_type);
endinterface : dtp_trace_if

/* src/dtp_trace_packer.sv */
// packs two processor cycles of trace status into one trace cycle
`timescale 1ns/1ps
module dtp_trace_packer (
   input wire logic clk,
   input wire logic rst,
   dtp_trace_if.packer tp
);
   import dtp_pkg::*;

   logic phase;
   logic pair_open;
   logic [EXEC_W-1:0] first_exec;
   logic [TSTAT_W-1:0] first_ts;
   logic [TRIG_W-1:0] first_trig;
   logic first_tin;
   logic [TRIG_W-1:0] pair_trig;

   // both halves of the pair, trigger gated by the debug modes
   assign pair_trig = (first_trig | tp.trig_type) & {TRIG_W{tp.trig_allow}};

   // divide by two: phase high marks the second cycle of a pair
   always_ff @(posedge clk) begin
      if (rst) begin
         phase <= 1'b0;
      end else begin
         phase <= ~phase;
      end
   end

   // first half of the pair; disable only blocks a pair not yet begun
   always_ff @(posedge clk) begin
      if (rst) begin
         pair_open <= 1'b0;
         first_exec <= '0;
         first_ts <= '0;
         first_trig <= '0;
         first_tin <= 1'b0;
      end else if (!phase) begin
         pair_open <= ~tp.trace_off;
         first_exec <= tp.exec_status;
         first_ts <= tp.trace_status;
         first_trig <= tp.trig_type;
         first_tin <= tp.trig_in;
      end
   end

   // broadcast a pair once it was opened, even if disable rose since
   always_ff @(posedge clk) begin
      if (rst) begin
         tp.trace_cycle <= 1'b0;
         tp.exec_first <= '0;
         tp.exec_second <= '0;
         tp.tstatus <= '0;
      end else if (phase && pair_open) begin
         tp.trace_cycle <= 1'b1;
         tp.exec_first <= first_exec;
         tp.exec_second <= tp.exec_status;
         tp.tstatus <= first_ts | tp.trace_status;
         if (first_tin || tp.trig_in) begin
            tp.tstatus[TS_TRIG_BIT] <= 1'b1;
         end
      end else begin
         tp.trace_cycle <= 1'b0;
      end
   end

   // trigger outputs follow the pair boundary and hold until the next
   always_ff @(posedge clk) begin
      if (rst) begin
         tp.trigger <= 1'b0;
         tp.trigger_type <= '0;
      end else if (phase) begin
         tp.trigger <= |pair_trig;
         tp.trigger_type <= pair_trig;
      end
   end
endmodule : dtp_trace_packer

/* src/dtp_port.sv */
// processor-side debug halt, writeback report and real-time trace port
//
// Our own choices: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
module dtp_port (
   input wire logic clk,
   input wire logic rst,
   // register port
   input wire logic [dtp_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [dtp_pkg::DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [dtp_pkg::DATA_W-1:0] reg_rdata,
   // debug pins from the outside
   input wire logic bus_hold_ack_in,
   input wire logic debug_halt_req_in,
   input wire logic uncond_event_in,
   input wire logic trigger_in,
   input wire logic trace_disable_in,
   // core pipeline side
   input wire logic wb_valid_in,
   input wire logic [dtp_pkg::WB_ADDR_W-1:0] wb_addr_in,
   input wire logic wb_complete_in,
   input wire logic [dtp_pkg::CORE_EVT_W-1:0] debug_event_in,
   input wire logic [dtp_pkg::EXEC_W-1:0] exec_status_in,
   input wire logic [dtp_pkg::TSTAT_W-1:0] trace_status_in,
   input wire logic ext_irq_in,
   input wire logic timer_irq_in,
   input wire logic apu_load_valid_in,
   output logic core_hold_out,
   output logic debug_irq_out,
   // debug outputs
   output logic writeback_full_out,
   output logic [dtp_pkg::WB_ADDR_W-1:0] writeback_addr_out,
   output logic writeback_complete_out,
   output logic wait_enable_out,
   output logic halt_ack_out,
   output logic coproc_load_valid_out,
   // trace outputs
   output logic trigger_out,
   output logic [dtp_pkg::TRIG_W-1:0] trigger_type_out,
   output logic trace_cycle_out,
   output logic [dtp_pkg::EXEC_W-1:0] exec_status_first_out,
   output logic [dtp_pkg::EXEC_W-1:0] exec_status_second_out,
   output logic [dtp_pkg::TSTAT_W-1:0] trace_status_out
);
   import dtp_pkg::*;

   // pin index inside the synchroniser bank
   localparam int PIN_HOLD = 0;
   localparam int PIN_HALT = 1;
   localparam int PIN_UDE = 2;
   localparam int PIN_TRIG = 3;
   localparam int PIN_TOFF = 4;

   logic [PIN_CNT-1:0] pin_meta;
   logic [PIN_CNT-1:0] pin_sync;
   logic ude_last;
   logic ude_rise;
   logic bus_held;
   logic halt_req;

   logic msr_we;
   logic uncond_event_flag;
   logic internal_debug_mode_bit;
   logic external_debug_mode_bit;
   logic serial_halt_cmd;
   logic event_stop;

   dtp_halt_type halt_state;
   dtp_halt_type next_halt_state;
   logic halt_want;
   logic next_we;

   logic wr_msr;
   logic wr_dsr;
   logic wr_dcr;
   logic wr_hcmd;
   logic [DATA_W-1:0] rd_word;

   dtp_trace_if trc ();

   // two-stage synchronisers on every pin; left without reset so a halt
   // request held through reset is already visible when reset lets go
   always_ff @(posedge clk) begin
      pin_meta <= {trace_disable_in, trigger_in, uncond_event_in,
                   debug_halt_req_in, bus_hold_ack_in};
      pin_sync <= pin_meta;
   end

   // edge detector reads only the second stage
   always_ff @(posedge clk) begin
      if (rst) begin
         ude_last <= 1'b0;
      end else begin
         ude_last <= pin_sync[PIN_UDE];
      end
   end

   assign ude_rise = pin_sync[PIN_UDE] & ~ude_last;
   assign bus_held = pin_sync[PIN_HOLD];
   assign halt_req = pin_sync[PIN_HALT];

   // write decode
   assign wr_msr = reg_wr && (reg_addr == REG_MSR);
   assign wr_dsr = reg_wr && (reg_addr == REG_DSR);
   assign wr_dcr = reg_wr && (reg_addr == REG_DCR);
   assign wr_hcmd = reg_wr && (reg_addr == REG_HCMD);

   // wait enable: interrupts and reset end wait; an interrupt in the same
   // cycle as a software set wins so a wake-up is never lost
   always_comb begin
      next_we = msr_we;
      if (wr_msr) begin
         next_we = reg_wdata[MSR_WE_BIT];
      end
      if (ext_irq_in || timer_irq_in) begin
         next_we = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         msr_we <= 1'b0;
      end else begin
         msr_we <= next_we;
      end
   end

   // debug mode control bits
   always_ff @(posedge clk) begin
      if (rst) begin
         {external_debug_mode_bit, internal_debug_mode_bit} <= RST_DCR;
      end else if (wr_dcr) begin
         internal_debug_mode_bit <= reg_wdata[DCR_IDM_BIT];
         external_debug_mode_bit <= reg_wdata[DCR_EDM_BIT];
      end
   end

   // unconditional event flag: write one to clear, a new event wins
   always_ff @(posedge clk) begin
      if (rst) begin
         uncond_event_flag <= 1'b0;
      end else if (ude_rise) begin
         uncond_event_flag <= 1'b1;
      end else if (wr_dsr && reg_wdata[DSR_UDE_BIT]) begin
         uncond_event_flag <= 1'b0;
      end
   end

   // serial halt command never survives reset
   always_ff @(posedge clk) begin
      if (rst) begin
         serial_halt_cmd <= 1'b0;
      end else if (wr_hcmd) begin
         serial_halt_cmd <= reg_wdata[HCMD_HALT_BIT];
      end
   end

   // external debug mode turns an unconditional event into a stop that
   // holds until the debugger writes one to release it; event wins
   always_ff @(posedge clk) begin
      if (rst) begin
         event_stop <= 1'b0;
      end else if (ude_rise && external_debug_mode_bit) begin
         event_stop <= 1'b1;
      end else if (wr_hcmd && reg_wdata[HCMD_STOP_BIT]) begin
         event_stop <= 1'b0;
      end
   end

   // internal debug mode: flag raises the debug interrupt as a level
   always_ff @(posedge clk) begin
      if (rst) begin
         debug_irq_out <= 1'b0;
      end else begin
         debug_irq_out <= uncond_event_flag & internal_debug_mode_bit;
      end
   end

   // halt sequencing; entry waits while another master owns the bus
   assign halt_want = halt_req | serial_halt_cmd | event_stop;

   always_comb begin
      next_halt_state = halt_state;
      unique case (halt_state)
         HLT_RUN: begin
            if (halt_want) begin
               next_halt_state = bus_held ? HLT_PEND : HLT_STOP;
            end
         end
         HLT_PEND: begin
            if (!halt_want) begin
               next_halt_state = HLT_RUN;
            end else if (!bus_held) begin
               next_halt_state = HLT_STOP;
            end
         end
         HLT_STOP: begin
            if (!halt_want) begin
               next_halt_state = HLT_RUN;
            end
         end
         default: begin
            next_halt_state = HLT_RUN;
         end
      endcase
   end

   // a request already high in reset leaves reset in the stopped state
   always_ff @(posedge clk) begin
      if (rst) begin
         halt_state <= halt_req ? HLT_STOP : HLT_RUN;
      end else begin
         halt_state <= next_halt_state;
      end
   end

   // only instruction flow is held; this block and the clock run on
   always_ff @(posedge clk) begin
      if (rst) begin
         halt_ack_out <= halt_req;
         core_hold_out <= halt_req;
      end else begin
         halt_ack_out <= (next_halt_state == HLT_STOP);
         core_hold_out <= (next_halt_state != HLT_RUN) | next_we;
      end
   end

   // wait enable mirrors the machine state bit
   always_ff @(posedge clk) begin
      if (rst) begin
         wait_enable_out <= 1'b0;
      end else begin
         wait_enable_out <= next_we;
      end
   end

   // writeback report; address is held when the stage empties
   always_ff @(posedge clk) begin
      if (rst) begin
         writeback_full_out <= 1'b0;
         writeback_addr_out <= '0;
         writeback_complete_out <= 1'b0;
      end else begin
         writeback_full_out <= wb_valid_in;
         writeback_complete_out <= wb_valid_in & wb_complete_in;
         if (wb_valid_in) begin
            writeback_addr_out <= wb_addr_in;
         end
      end
   end

   // coprocessor load strobe, registered for synchronous sampling
   always_ff @(posedge clk) begin
      if (rst) begin
         coproc_load_valid_out <= 1'b0;
      end else begin
         coproc_load_valid_out <= apu_load_valid_in;
      end
   end

   // trace feed: core events in their type positions, unconditional on top
   assign trc.exec_status = exec_status_in;
   assign trc.trace_status = trace_status_in;
   assign trc.trig_type = {ude_rise, debug_event_in};
   assign trc.trig_allow = ~internal_debug_mode_bit & ~external_debug_mode_bit;
   assign trc.trig_in = pin_sync[PIN_TRIG];
   assign trc.trace_off = pin_sync[PIN_TOFF];

   dtp_trace_packer u_packer (
      .clk (clk),
      .rst (rst),
      .tp (trc.packer)
   );

   // packer drives these straight from its flip-flops
   assign trace_cycle_out = trc.trace_cycle;
   assign exec_status_first_out = trc.exec_first;
   assign exec_status_second_out = trc.exec_second;
   assign trace_status_out = trc.tstatus;
   assign trigger_out = trc.trigger;
   assign trigger_type_out = trc.trigger_type;

   // read mux; unmapped offsets read zero
   always_comb begin
      rd_word = RST_WORD;
      unique case (reg_addr)
         REG_MSR: begin
            rd_word[MSR_WE_BIT] = msr_we;
         end
         REG_DSR: begin
            rd_word[DSR_UDE_BIT] = uncond_event_flag;
            rd_word[DSR_HALTED_BIT] = (halt_state == HLT_STOP);
            rd_word[DSR_PEND_BIT] = (halt_state == HLT_PEND);
            rd_word[DSR_BUSHOLD_BIT] = bus_held;
            rd_word[DSR_WAIT_BIT] = msr_we;
         end
         REG_DCR: begin
            rd_word[DCR_IDM_BIT] = internal_debug_mode_bit;
            rd_word[DCR_EDM_BIT] = external_debug_mode_bit;
         end
         REG_HCMD: begin
            rd_word[HCMD_HALT_BIT] = serial_halt_cmd;
            rd_word[HCMD_STOP_BIT] = event_stop;
         end
         default: begin
            rd_word = RST_WORD;
         end
      endcase
   end

   // read data stand only in the cycle after the strobe
   always_ff @(posedge clk) begin
      if (rst) begin
         reg_rdata <= RST_WORD;
      end else begin
         reg_rdata <= reg_rd ? rd_word : RST_WORD;
      end
   end
endmodule : dtp_port

/* sim/dtp_glue.sv */
// debugger and trace-tool glue model at the far side of the port
`timescale 1ns/1ps
module dtp_glue (
   input wire logic halt_n,
   input wire logic loop_en,
   input wire logic trigger_out,
   output logic debug_halt_req_in,
   output logic trigger_in
);
   // debugger halt is low-true, the port wants high-true; clocks never gated here
   assign debug_halt_req_in = ~halt_n;
   // with no trace tool the trigger is wrapped straight back
   assign trigger_in = loop_en & trigger_out;
endmodule : dtp_glue

/* sim/dtp_port_chk.sv */
// concurrent checks on the debug and trace port pins
`timescale 1ns/1ps
module dtp_port_chk (
   input wire logic clk,
   input wire logic rst,
   input wire logic wb_valid_in,
   input wire logic [dtp_pkg::WB_ADDR_W-1:0] wb_addr_in,
   input wire logic wb_complete_in,
   input wire logic apu_load_valid_in,
   input wire logic debug_halt_req_in,
   input wire logic bus_hold_ack_in,
   input wire logic ext_irq_in,
   input wire logic timer_irq_in,
   input wire logic trace_disable_in,
   input wire logic writeback_full_out,
   input wire logic [dtp_pkg::WB_ADDR_W-1:0] writeback_addr_out,
   input wire logic writeback_complete_out,
   input wire logic coproc_load_valid_out,
   input wire logic halt_ack_out,
   input wire logic core_hold_out,
   input wire logic wait_enable_out,
   input wire logic trace_cycle_out,
   input wire logic trigger_out
);
   import dtp_pkg::*;
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   AST_WB_FULL: assert property (!$past(rst) |-> writeback_full_out == $past(wb_valid_in))
      else $error("writeback full does not track the pipeline stage");
   AST_WB_ADDR: assert property (writeback_full_out |-> writeback_addr_out == $past(wb_addr_in))
      else $error("writeback address wrong while full");
   AST_WB_CMPL: assert property (!$past(rst) |->
      writeback_complete_out == $past(wb_valid_in & wb_complete_in))
      else $error("writeback complete wrong");
   AST_APU_LOAD: assert property (!$past(rst) |->
      coproc_load_valid_out == $past(apu_load_valid_in))
      else $error("coprocessor load valid wrong");
   AST_HALT_ACK: assert property ((debug_halt_req_in && !bus_hold_ack_in)[*5] |-> halt_ack_out)
      else $error("halt request not acknowledged");
   AST_ACK_HOLD: assert property ($rose(halt_ack_out) |-> core_hold_out)
      else $error("halt acknowledged while core still runs");
   AST_WAIT_HOLD: assert property (wait_enable_out |-> core_hold_out)
      else $error("wait state does not hold the core");
   AST_WAKE: assert property ((ext_irq_in || timer_irq_in) |-> ##[1:2] !wait_enable_out)
      else $error("interrupt did not end wait state");
   AST_TRC_PULSE: assert property (trace_cycle_out |=> !trace_cycle_out)
      else $error("trace cycle longer than one clock");
   AST_TRC_RATE: assert property ((!trace_disable_in)[*8] |->
      (trace_cycle_out || $past(trace_cycle_out)))
      else $error("trace cycle missing while enabled");
   AST_RST_CLEAN: assert property ($fell(rst) |->
      !trace_cycle_out && !trigger_out && !writeback_full_out)
      else $error("outputs not clear out of reset");
   cover property ($rose(halt_ack_out));
   cover property (core_hold_out && bus_hold_ack_in && !halt_ack_out);
   cover property (trace_cycle_out && trigger_out);
   cover property ($fell(wait_enable_out));
endmodule : dtp_port_chk

bind dtp_port dtp_port_chk dtp_port_chk_i (
   .clk(clk), .rst(rst), .wb_valid_in(wb_valid_in), .wb_addr_in(wb_addr_in),
   .wb_complete_in(wb_complete_in), .apu_load_valid_in(apu_load_valid_in),
   .debug_halt_req_in(debug_halt_req_in), .bus_hold_ack_in(bus_hold_ack_in),
   .ext_irq_in(ext_irq_in), .timer_irq_in(timer_irq_in), .trace_disable_in(trace_disable_in),
   .writeback_full_out(writeback_full_out), .writeback_addr_out(writeback_addr_out),
   .writeback_complete_out(writeback_complete_out), .coproc_load_valid_out(coproc_load_valid_out),
   .halt_ack_out(halt_ack_out), .core_hold_out(core_hold_out),
   .wait_enable_out(wait_enable_out), .trace_cycle_out(trace_cycle_out), .trigger_out(trigger_out));

/* sim/dtp_port_tb.sv */
// self-checking bench for the debug and trace port
`timescale 1ns/1ps
module dtp_port_tb;
   import dtp_pkg::*;
   logic clk, rst, reg_wr, reg_rd, rd_d, halt_n, loop_en, ph, open, t0, saw10;
   logic bus_hold_ack_in, uncond_event_in, trace_disable_in, ext_irq_in, timer_irq_in;
   logic debug_halt_req_in, trigger_in, wb_valid_in, wb_complete_in, apu_load_valid_in;
   logic core_hold_out, debug_irq_out, writeback_full_out, writeback_complete_out;
   logic wait_enable_out, halt_ack_out, coproc_load_valid_out, trigger_out, trace_cycle_out;
   logic dis_s1, dis_s2, trg_s1, trg_s2;
   logic [ADDR_W-1:0] reg_addr;
   logic [DATA_W-1:0] reg_wdata, reg_rdata;
   logic [WB_ADDR_W-1:0] wb_addr_in, writeback_addr_out;
   logic [CORE_EVT_W-1:0] debug_event_in, ev0;
   logic [EXEC_W-1:0] exec_status_in, exec_status_first_out, exec_status_second_out, e0;
   logic [TSTAT_W-1:0] trace_status_in, trace_status_out, ts0;
   logic [TRIG_W-1:0] trigger_type_out, tt;
   logic [1:0] dcr_m;
   logic [39:0] pk;
   logic [31:0] rd_q[$];
   logic [39:0] trc_q[$];
   int err_total, checks, cyc, msk_until;

   dtp_port dtp_port_i (
      .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .bus_hold_ack_in(bus_hold_ack_in),
      .debug_halt_req_in(debug_halt_req_in), .uncond_event_in(uncond_event_in),
      .trigger_in(trigger_in), .trace_disable_in(trace_disable_in), .wb_valid_in(wb_valid_in),
      .wb_addr_in(wb_addr_in), .wb_complete_in(wb_complete_in), .debug_event_in(debug_event_in),
      .exec_status_in(exec_status_in), .trace_status_in(trace_status_in),
      .ext_irq_in(ext_irq_in), .timer_irq_in(timer_irq_in),
      .apu_load_valid_in(apu_load_valid_in), .core_hold_out(core_hold_out),
      .debug_irq_out(debug_irq_out), .writeback_full_out(writeback_full_out),
      .writeback_addr_out(writeback_addr_out), .writeback_complete_out(writeback_complete_out),
      .wait_enable_out(wait_enable_out), .halt_ack_out(halt_ack_out),
      .coproc_load_valid_out(coproc_load_valid_out), .trigger_out(trigger_out),
      .trigger_type_out(trigger_type_out), .trace_cycle_out(trace_cycle_out),
      .exec_status_first_out(exec_status_first_out),
      .exec_status_second_out(exec_status_second_out), .trace_status_out(trace_status_out));
   dtp_glue dtp_glue_i (.halt_n(halt_n), .loop_en(loop_en), .trigger_out(trigger_out),
      .debug_halt_req_in(debug_halt_req_in), .trigger_in(trigger_in));

   // clock at 25 MHz
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : cmp

   task automatic look(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : look

   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask : wr

   // expected word queued now, judged by the monitor two cycles later
   task automatic rd(input logic [3:0] a, input logic [31:0] e);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      rd_q.push_back(e);
      @(posedge clk);
      reg_rd <= 1'b0;
   endtask : rd

   task automatic wait_ack(input logic v);
      int n;
      n = 0;
      while (halt_ack_out !== v && n < 20) begin
         look(1);
         n++;
      end
      cmp(32'(halt_ack_out), 32'(v));
   endtask : wait_ack

   task automatic print_verdict();
      $display("checks=%0d err_total=%0d", checks, err_total);
      if (err_total == 0 && checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : print_verdict

   // core-side traffic every cycle; events kept sparse so triggers toggle
   always @(posedge clk) begin
      {wb_valid_in, wb_complete_in, apu_load_valid_in, exec_status_in, trace_status_in} <=
         9'($urandom);
      wb_addr_in <= 30'($urandom);
      debug_event_in <= 10'($urandom) & 10'($urandom) & 10'($urandom);
   end

   // trace predictor: pairs counted from reset, pins seen through two flops
   always @(posedge clk) begin
      dis_s1 <= trace_disable_in;
      dis_s2 <= dis_s1;
      trg_s1 <= trigger_in;
      trg_s2 <= trg_s1;
      cyc <= cyc + 1;
      if (rst) begin
         ph <= 1'b0;
         open <= 1'b0;
         trc_q.delete();
      end else begin
         ph <= ~ph;
         if (!ph) begin
            open <= !dis_s2;
            {e0, ts0, ev0, t0} <= {exec_status_in, trace_status_in, debug_event_in, trg_s2};
         end else if (open) begin
            tt = (dcr_m == 2'h0) ? {1'b0, ev0 | debug_event_in} : 11'h0;
            trc_q.push_back({(cyc < msk_until) ? 20'h0_00FF : 20'hF_FFFF, |tt, tt, e0,
               exec_status_in, ts0 | trace_status_in | {t0 | trg_s2, 3'h0}});
         end
      end
   end

   // monitor: read data and trace cycles against the oldest note
   always @(posedge clk) begin
      rd_d <= reg_rd;
      if (trigger_type_out[TRIG_UNCOND_BIT] === 1'b1) saw10 <= 1'b1;
      if (rd_d && rd_q.size() > 0) cmp(reg_rdata, rd_q.pop_front());
      if (trace_cycle_out === 1'b1) begin
         if (trc_q.size() == 0) begin
            cmp(32'h1, 32'h0);
         end else begin
            pk = trc_q.pop_front();
            cmp(32'({trigger_out, trigger_type_out, exec_status_first_out, exec_status_second_out,
               trace_status_out} & pk[39:20]), 32'(pk[19:0] & pk[39:20]));
         end
      end
   end

   initial begin
      // bus free in reset, halt request held through it
      {rst, halt_n, reg_wr, reg_rd, loop_en, rd_d, saw10, bus_hold_ack_in} = 8'h80;
      {uncond_event_in, trace_disable_in, ext_irq_in, timer_irq_in, ph, open} = 6'h00;
      {reg_addr, reg_wdata, dcr_m, cyc, msk_until, err_total, checks} = '0;
      {wb_valid_in, wb_complete_in, apu_load_valid_in, exec_status_in, trace_status_in} = '0;
      {wb_addr_in, debug_event_in} = '0;
      void'($urandom(29635));
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      look(1);
      cmp(32'(halt_ack_out), 32'h1);
      cmp(32'(core_hold_out), 32'h1);
      @(posedge clk);
      halt_n <= 1'b1;
      wait_ack(1'b0);
      rd(REG_MSR, 32'h0);
      rd(REG_DSR, 32'h0);
      rd(REG_DCR, 32'h0);
      rd(REG_HCMD, 32'h0);
      wr(4'h2, 32'hFFFF_FFFF);
      rd(4'h2, 32'h0);
      // wait state ended once by each interrupt source
      for (int i = 0; i < 2; i++) begin
         wr(REG_MSR, 32'h1);
         look(1);
         cmp(32'(wait_enable_out), 32'h1);
         cmp(32'(core_hold_out), 32'h1);
         rd(REG_DSR, 32'h0000_0010);
         @(posedge clk);
         {ext_irq_in, timer_irq_in} <= (i == 0) ? 2'h2 : 2'h1;
         @(posedge clk);
         {ext_irq_in, timer_irq_in} <= 2'h0;
         look(3);
         cmp(32'(wait_enable_out), 32'h0);
      end
      wr(REG_MSR, 32'h1);
      wr(REG_MSR, 32'h0);
      look(1);
      cmp(32'(wait_enable_out), 32'h0);
      // serial halt and wait state both dropped by reset
      wr(REG_MSR, 32'h1);
      wr(REG_HCMD, 32'h1);
      wait_ack(1'b1);
      rd(REG_DSR, 32'h0000_0012);
      @(posedge clk);
      rst <= 1'b1;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      look(4);
      cmp(32'(halt_ack_out), 32'h0);
      cmp(32'(wait_enable_out), 32'h0);
      rd(REG_HCMD, 32'h0);
      // halt while another master owns the bus
      @(posedge clk);
      bus_hold_ack_in <= 1'b1;
      @(posedge clk);
      halt_n <= 1'b0;
      look(10);
      cmp(32'(halt_ack_out), 32'h0);
      cmp(32'(core_hold_out), 32'h1);
      rd(REG_DSR, 32'h0000_000C);
      @(posedge clk);
      bus_hold_ack_in <= 1'b0;
      wait_ack(1'b1);
      @(posedge clk);
      halt_n <= 1'b1;
      wait_ack(1'b0);
      // unconditional event in each debug mode; triggers unjudged around mode changes
      for (int m = 0; m < 3; m++) begin
         msk_until <= cyc + 60;
         wr(REG_DCR, 32'(m));
         dcr_m <= 2'(m);
         saw10 <= 1'b0;
         @(posedge clk);
         uncond_event_in <= 1'b1;
         @(posedge clk);
         uncond_event_in <= 1'b0;
         look(10);
         cmp(32'(debug_irq_out), 32'(m == 1));
         cmp(32'(halt_ack_out), 32'(m == 2));
         cmp(32'(saw10), 32'(m == 0));
         rd(REG_DSR, (m == 2) ? 32'h3 : 32'h1);
         wr(REG_DSR, 32'h1);
         wr(REG_HCMD, 32'h2);
         wr(REG_DCR, 32'h0);
         dcr_m <= 2'h0;
         look(4);
         cmp(32'(halt_ack_out), 32'h0);
         rd(REG_DSR, 32'h0);
      end
      // trigger wrapped back, then trace disabled across several pairs
      look(60);
      @(posedge clk);
      loop_en <= 1'b1;
      look(60);
      @(posedge clk);
      loop_en <= 1'b0;
      trace_disable_in <= 1'b1;
      look(30);
      @(posedge clk);
      trace_disable_in <= 1'b0;
      look(200);
      cmp(32'(trc_q.size() <= 1), 32'h1);
      print_verdict();
   end
endmodule : dtp_port_tb
